// *** rtl/mccr_main_clock_ctrl.sv ***
// Main clock controller: core prescaler, clock-out pin, time base, power modes and AXI4-Lite registers.
// Behaviour
// [R1] Core clock chosen by slow divider select and slow mode select bits.
// [R2] Network peripheral clock is always oscillator over two, ignoring slow mode.
// [R3] Clock-out enable drives oscillator over two onto the alternate pin.
// [R4] Clock-out pin stops toggling during active-halt mode.
// [R5] Time-base select picks 32000, 64000, 160000 or 400000 oscillator cycles.
// [R6] New time-base selection applies only when the running period ends.
// [R7] Elapsed flag in bit 0 sets at period end; reading the register clears it.
// [R8] Interrupt requested only if flag, enable bit 1 and core mask inactive.
// [R9] Halt with interrupt enabled enters active halt instead of full halt.
// [R10] In wait the time base runs normally; its interrupt ends wait.
// [R11] In active halt the counter runs, registers freeze; interrupt ends it.
// [R12] In full halt counter and registers freeze until a halt-capable wake.
// [R13] The time-base interrupt cannot end full halt mode.
// [R14] Status register resets to 01h; bits 7:4 always read zero.
// [R15] Software avoids read-modify-write bit instructions on the status register.
// [R16] Prescaler, clock-out and time base work independently and simultaneously.
// [R17] Slow divider: 00 gives /4, 10 /8, 01 /16, 11 /32.
// [R18] Slow mode select 0 gives oscillator over two; 1 uses the divider.
// [R19] Clock-out enable is bit 5, resets to zero, frees pin when cleared.
// [R20] Time base restarts each period and sets the flag regardless of enable.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module mccr_main_clock_ctrl
	import mccr_pkg::*;
#(
	parameter logic [18:0] PERIOD_00 = MCCR_PERIOD_00,
	parameter logic [18:0] PERIOD_01 = MCCR_PERIOD_01,
	parameter logic [18:0] PERIOD_10 = MCCR_PERIOD_10,
	parameter logic [18:0] PERIOD_11 = MCCR_PERIOD_11
)
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	// AXI4-Lite slave.
	input  wire logic [MCCR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [MCCR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Core side, all on the oscillator clock.
	input  wire logic                   core_irq_mask,
	input  wire logic                   halt_insn,
	input  wire logic                   wait_insn,
	input  wire logic                   halt_wake,
	output logic                        timebase_irq,
	output mccr_pwr_t                   power_mode,
	// Generated clocks.
	output logic                        cpu_clk,
	output logic                        can_clk,
	output logic                        clock_out_o,
	output logic                        clock_out_oe
);

	mccr_csr_t  csr;
	mccr_misc_t misc;
	logic       frozen;
	logic       elapsed;
	logic       irq_req;
	logic [2:0] cpu_tap;
	logic       clkout_run;

	// Write and read channel bookkeeping.
	logic [MCCR_ADDR_W-1:0] wr_addr;
	logic [31:0]            wr_data;
	logic [3:0]             wr_strb;
	logic                   aw_got;
	logic                   w_got;
	logic                   wr_fire;
	logic                   wr_csr;
	logic                   wr_misc;
	logic                   rd_fire;
	logic                   rd_csr;
	logic                   rd_misc;

	// Registers freeze in active halt and full halt; wait leaves them alive.
	assign frozen = (power_mode == PWR_ACTIVE_HALT) || (power_mode == PWR_HALT); // [R11] [R12]

	// ---------------------------------------------------------------
	// Clock generation.
	// ---------------------------------------------------------------

	// Core clock tap; the slow divider codes are not in ascending order.
	always_comb begin
		if (!misc.slow_mode_select) begin
			cpu_tap = MCCR_TAP_DIV2; // [R18] [R1]
		end else begin
			unique case (misc.slow_divider_select)
				2'b00: cpu_tap = MCCR_TAP_DIV4;  // [R17]
				2'b10: cpu_tap = MCCR_TAP_DIV8;  // [R17]
				2'b01: cpu_tap = MCCR_TAP_DIV16; // [R17]
				2'b11: cpu_tap = MCCR_TAP_DIV32; // [R17]
			endcase
		end
	end

	// The core clock stops in either halt mode so the core really sleeps.
	mccr_divider u_cpu_div (
		.clk     (clk),
		.resetn  (resetn),
		.tap     (cpu_tap),
		.enable  (!frozen),
		.clk_out (cpu_clk)
	);

	// The network peripheral clock bypasses the prescaler entirely.
	mccr_divider u_can_div (
		.clk     (clk),
		.resetn  (resetn),
		.tap     (MCCR_TAP_DIV2), // [R2] [R16]
		.enable  (1'b1),
		.clk_out (can_clk)
	);

	// Clock-out toggles only when enabled and not in active halt, saving pin power.
	assign clkout_run = misc.clock_out_enable && (power_mode != PWR_ACTIVE_HALT); // [R3] [R4]

	mccr_divider u_out_div (
		.clk     (clk),
		.resetn  (resetn),
		.tap     (MCCR_TAP_DIV2),
		.enable  (clkout_run), // [R3] [R16]
		.clk_out (clock_out_o)
	);

	// The pin is handed to the alternate function only while the enable bit is set.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clock_out_oe <= 1'b0;
		end else begin
			clock_out_oe <= misc.clock_out_enable; // [R19]
		end
	end

	// ---------------------------------------------------------------
	// Time base.
	// ---------------------------------------------------------------

	// Counter runs in run, wait and active halt, and stops only in full halt.
	mccr_timebase #(
		.PERIOD_00 (PERIOD_00), // [R5]
		.PERIOD_01 (PERIOD_01),
		.PERIOD_10 (PERIOD_10),
		.PERIOD_11 (PERIOD_11)
	) u_timebase (
		.clk     (clk),
		.resetn  (resetn),
		.run     (power_mode != PWR_HALT), // [R10] [R11] [R12] [R20]
		.select  (csr.timebase_select),    // [R6]
		.elapsed (elapsed)
	);

	// Interrupt request is the flag gated by enable and the core's mask.
	assign irq_req = csr.timebase_elapsed_flag && csr.timebase_irq_enable
		&& !core_irq_mask; // [R8]

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timebase_irq <= 1'b0;
		end else begin
			timebase_irq <= irq_req; // [R8]
		end
	end

	// ---------------------------------------------------------------
	// Power modes.
	// ---------------------------------------------------------------

	// The time-base request may end wait and active halt but never full halt.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			power_mode <= PWR_RUN;
		end else begin
			unique case (power_mode)
				PWR_RUN: begin
					if (halt_insn) begin
						power_mode <= csr.timebase_irq_enable ? PWR_ACTIVE_HALT
							: PWR_HALT; // [R9]
					end else if (wait_insn) begin
						power_mode <= PWR_WAIT;
					end
				end
				PWR_WAIT: begin
					if (irq_req || halt_wake) begin
						power_mode <= PWR_RUN; // [R10]
					end
				end
				PWR_ACTIVE_HALT: begin
					if (irq_req || halt_wake) begin
						power_mode <= PWR_RUN; // [R11]
					end
				end
				PWR_HALT: begin
					if (halt_wake) begin
						power_mode <= PWR_RUN; // [R12] [R13]
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite write path.
	// ---------------------------------------------------------------

	// Address and data are caught independently in either order.
	assign wr_fire = aw_got && w_got && !s_axi_bvalid;
	assign wr_csr  = wr_addr == MCCR_ADDR_CSR;
	assign wr_misc = wr_addr == MCCR_ADDR_MISC;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			aw_got        <= 1'b0;
			s_axi_awready <= 1'b1;
			wr_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got        <= 1'b1;
			s_axi_awready <= 1'b0;
			wr_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_got        <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			w_got        <= 1'b0;
			s_axi_wready <= 1'b1;
			wr_data      <= '0;
			wr_strb      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got        <= 1'b1;
			s_axi_wready <= 1'b0;
			wr_data      <= s_axi_wdata;
			wr_strb      <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_got        <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// Response one cycle after both halves are held; unmapped words answer SLVERR.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= MCCR_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_csr || wr_misc) ? MCCR_RESP_OKAY : MCCR_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read path.
	// ---------------------------------------------------------------

	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_csr  = s_axi_araddr == MCCR_ADDR_CSR;
	assign rd_misc = s_axi_araddr == MCCR_ADDR_MISC;

	// Data is sampled at the address handshake, which is also the clearing read.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= MCCR_RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= (rd_csr || rd_misc) ? MCCR_RESP_OKAY : MCCR_RESP_SLVERR;
			if (rd_csr) begin
				s_axi_rdata <= {24'h0, 4'h0, csr[3:0]}; // [R14]
			end else if (rd_misc) begin
				s_axi_rdata <= {24'h0, 2'h0, misc.clock_out_enable, 2'h0,
					misc.slow_divider_select, misc.slow_mode_select};
			end else begin
				s_axi_rdata <= '0;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Register state.
	// ---------------------------------------------------------------

	// Software fields of the status register; writes are dropped while frozen.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			csr.reserved            <= MCCR_CSR_RESET[7:4]; // [R14]
			csr.timebase_select     <= MCCR_CSR_RESET[3:2];
			csr.timebase_irq_enable <= MCCR_CSR_RESET[1];
		end else if (wr_fire && wr_csr && wr_strb[0] && !frozen) begin
			csr.reserved            <= 4'h0; // [R14]
			csr.timebase_select     <= wr_data[3:2];
			csr.timebase_irq_enable <= wr_data[1];
		end
	end

	// Flag sets on every period end; a set in the clearing cycle wins, so no event is lost.
	// A plain write does not touch the flag, which is why bit instructions are avoided.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			csr.timebase_elapsed_flag <= MCCR_CSR_RESET[0]; // [R14]
		end else if (elapsed) begin
			csr.timebase_elapsed_flag <= 1'b1; // [R7] [R20]
		end else if (rd_fire && rd_csr && !frozen) begin
			csr.timebase_elapsed_flag <= 1'b0; // [R7] [R15]
		end
	end

	// Clock control bits of the miscellaneous register; other bits belong elsewhere.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			misc <= MCCR_MISC_RESET; // [R19]
		end else if (wr_fire && wr_misc && wr_strb[0] && !frozen) begin
			misc.reserved_hi         <= 2'h0;
			misc.clock_out_enable    <= wr_data[5]; // [R19]
			misc.reserved_mid        <= 2'h0;
			misc.slow_divider_select <= wr_data[2:1]; // [R1]
			misc.slow_mode_select    <= wr_data[0];   // [R1]
		end
	end

endmodule

`default_nettype wire

// *** rtl/mccr_pkg.sv ***
// Package with register map, field layouts, states and time-base periods of the clock controller.
package mccr_pkg;

	// Register indices as printed; the AXI byte address is four times the index.
	localparam logic [7:0]  MCCR_IDX_MISC   = 8'h20;
	localparam logic [7:0]  MCCR_IDX_CSR    = 8'h29;
	localparam logic [11:0] MCCR_ADDR_MISC  = {2'h0, MCCR_IDX_MISC, 2'h0};
	localparam logic [11:0] MCCR_ADDR_CSR   = {2'h0, MCCR_IDX_CSR, 2'h0};
	localparam int          MCCR_ADDR_W     = 12;

	// Reset values of the two registers.
	localparam logic [7:0]  MCCR_CSR_RESET  = 8'h01;
	localparam logic [7:0]  MCCR_MISC_RESET = 8'h00;

	// AXI4-Lite response codes.
	localparam logic [1:0]  MCCR_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  MCCR_RESP_SLVERR = 2'h2;

	// Time-base periods in oscillator cycles.
	localparam int          MCCR_TB_W        = 19;
	localparam logic [18:0] MCCR_PERIOD_00   = 19'd32000;
	localparam logic [18:0] MCCR_PERIOD_01   = 19'd64000;
	localparam logic [18:0] MCCR_PERIOD_10   = 19'd160000;
	localparam logic [18:0] MCCR_PERIOD_11   = 19'd400000;

	// Divider taps: tap k of the free counter gives the oscillator divided by 2^(k+1).
	localparam int          MCCR_DIV_W       = 5;
	localparam logic [2:0]  MCCR_TAP_DIV2    = 3'd0;
	localparam logic [2:0]  MCCR_TAP_DIV4    = 3'd1;
	localparam logic [2:0]  MCCR_TAP_DIV8    = 3'd2;
	localparam logic [2:0]  MCCR_TAP_DIV16   = 3'd3;
	localparam logic [2:0]  MCCR_TAP_DIV32   = 3'd4;

	// Clock/time-base control and status register; upper nibble reads zero.
	typedef struct packed {
		logic [3:0] reserved;
		logic [1:0] timebase_select;
		logic       timebase_irq_enable;
		logic       timebase_elapsed_flag;
	} mccr_csr_t;

	// Miscellaneous control register one; only the clock bits live in this block.
	typedef struct packed {
		logic [1:0] reserved_hi;
		logic       clock_out_enable;
		logic [1:0] reserved_mid;
		logic [1:0] slow_divider_select;
		logic       slow_mode_select;
	} mccr_misc_t;

	// Power modes of the device as seen by this block.
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_WAIT,
		PWR_ACTIVE_HALT,
		PWR_HALT
	} mccr_pwr_t;

endpackage

// *** rtl/mccr_divider.sv ***
// Free-running power-of-two divider with a selectable tap and a gated, registered output.
`timescale 1ns/1ns
`default_nettype none

module mccr_divider
	import mccr_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [2:0] tap,
	input  wire logic       enable,
	output logic            clk_out
);

	logic [MCCR_DIV_W-1:0] cnt;
	logic [MCCR_DIV_W-1:0] next_cnt;

	assign next_cnt = cnt + 5'd1;

	// The counter never stops, so a tap change lands on an existing phase.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// A disabled output parks low instead of freezing mid-cycle.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			clk_out <= 1'b0;
		end else begin
			clk_out <= enable & next_cnt[tap];
		end
	end

endmodule

`default_nettype wire

// *** rtl/mccr_timebase.sv ***
// Real-time time-base counter with period select that is adopted only at the end of a period.
`timescale 1ns/1ns
`default_nettype none

module mccr_timebase
	import mccr_pkg::*;
#(
	parameter logic [18:0] PERIOD_00 = MCCR_PERIOD_00,
	parameter logic [18:0] PERIOD_01 = MCCR_PERIOD_01,
	parameter logic [18:0] PERIOD_10 = MCCR_PERIOD_10,
	parameter logic [18:0] PERIOD_11 = MCCR_PERIOD_11
)
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       run,
	input  wire logic [1:0] select,
	output logic            elapsed
);

	logic [MCCR_TB_W-1:0] cnt;
	logic [1:0]           active_select;
	logic [MCCR_TB_W-1:0] last;
	logic                 at_end;

	// Terminal count of the period that is currently running.
	always_comb begin
		unique case (active_select)
			2'b00: last = PERIOD_00 - 19'd1;
			2'b01: last = PERIOD_01 - 19'd1;
			2'b10: last = PERIOD_10 - 19'd1;
			2'b11: last = PERIOD_11 - 19'd1;
		endcase
	end

	assign at_end = run & (cnt >= last);

	// Counter wraps on its own and holds still while run is low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
		end else if (at_end) begin
			cnt <= '0;
		end else if (run) begin
			cnt <= cnt + 19'd1;
		end
	end

	// A new selection is taken only at the wrap, so no period is shortened or stretched.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			active_select <= MCCR_CSR_RESET[3:2];
		end else if (at_end) begin
			active_select <= select;
		end
	end

	// One-cycle pulse in the cycle after the last cycle of every period.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			elapsed <= 1'b0;
		end else begin
			elapsed <= at_end;
		end
	end

endmodule

`default_nettype wire

// *** tb/mccr_checker.sv ***
// Port-level assertions for the main clock controller, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module mccr_checker
	import mccr_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        core_irq_mask,
	input wire logic        halt_insn,
	input wire logic        halt_wake,
	input wire logic        timebase_irq,
	input wire mccr_pwr_t   power_mode,
	input wire logic        cpu_clk,
	input wire logic        can_clk,
	input wire logic        clock_out_o
);
	// One clock domain, so clocking and reset are declared once for all properties.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// Registered outputs lag their cause by one edge, hence the past values below.
	chk_can_toggle: assert property ($past(resetn, 2) |-> can_clk != $past(can_clk))
		else $error("network clock did not toggle");
	chk_irq_masked: assert property (timebase_irq |-> !$past(core_irq_mask))
		else $error("request raised while masked");
	chk_out_stops: assert property ($past(power_mode) == PWR_ACTIVE_HALT |-> !clock_out_o)
		else $error("clock out runs in active halt");
	chk_cpu_stops: assert property ($past(power_mode) >= PWR_ACTIVE_HALT |-> !cpu_clk)
		else $error("core clock runs in halt");
	// The bench has ready up whenever valid is high, so each check also covers the retiring edge.
	chk_b_hold: assert property (s_axi_bvalid |=> (if ($past(s_axi_bready)) !s_axi_bvalid
		else (s_axi_bvalid && $stable(s_axi_bresp))))
		else $error("write response not held or not retired");
	chk_r_hold: assert property (s_axi_rvalid |=> (if ($past(s_axi_rready)) !s_axi_rvalid
		else (s_axi_rvalid && $stable(s_axi_rdata))))
		else $error("read data not held or not retired");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
		else $error("read answer late or upper bits set");
	chk_halt_entry: assert property (power_mode == PWR_RUN && halt_insn |=> power_mode >= PWR_ACTIVE_HALT)
		else $error("halt instruction ignored");
	chk_halt_holds: assert property (power_mode == PWR_HALT && !halt_wake |=> power_mode == PWR_HALT)
		else $error("full halt left without wake");
	chk_wake_exit: assert property ($rose(timebase_irq) && $past(power_mode) inside {PWR_WAIT, PWR_ACTIVE_HALT} |-> power_mode == PWR_RUN)
		else $error("request did not end low power mode");

	// Main scenarios that the bench is expected to reach.
	cov_active_halt: cover property (power_mode == PWR_ACTIVE_HALT);
	cov_wait: cover property (power_mode == PWR_WAIT);
	cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == MCCR_RESP_SLVERR);
endmodule

bind mccr_main_clock_ctrl mccr_checker u_chk (
	.clk, .resetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .core_irq_mask, .halt_insn, .halt_wake,
	.timebase_irq, .power_mode, .cpu_clk, .can_clk, .clock_out_o
);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the main clock controller against expected values written into its sequence.
`timescale 1ns/1ns
`default_nettype none
module testbench
	import mccr_pkg::*;
;
	// Short periods keep the run brief; every period check is derived from them.
	localparam logic [18:0] P0 = 19'd200;
	localparam logic [18:0] P1 = 19'd300;
	localparam logic [18:0] P2 = 19'd500;
	localparam logic [18:0] P3 = 19'd700;
	logic        clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, mask, hins, wins, wake;
	logic        irq, cpu, can, cko, coe;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdv, rnd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	mccr_pwr_t   pm;
	int          miscompares, n_compared, cyc, seed, i, t0, t1, p;
	int          per [4];
	int          div [4];

	mccr_main_clock_ctrl #(.PERIOD_00(P0), .PERIOD_01(P1), .PERIOD_10(P2), .PERIOD_11(P3)) uut (
		.clk(clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.core_irq_mask(mask), .halt_insn(hins), .wait_insn(wins), .halt_wake(wake),
		.timebase_irq(irq), .power_mode(pm), .cpu_clk(cpu), .can_clk(can),
		.clock_out_o(cko), .clock_out_oe(coe)
	);

	// Free-running oscillator clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Cycle count for interval checks; a hang ends the run as a mismatch.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Bus write: address and data offered together, each released when taken.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		rnd = $random(seed);
		awaddr <= a;
		wdata <= {rnd[31:8], d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdv = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// One-cycle instruction pulse; the mode is settled when the task returns.
	task automatic pulse(input logic halt);
		if (halt) hins <= 1'b1;
		else wins <= 1'b1;
		@(posedge clk);
		{hins, wins} <= 2'b00;
		@(posedge clk);
	endtask

	function automatic logic pick(input int w);
		return w == 0 ? cpu : (w == 1 ? can : cko);
	endfunction

	// Period between two rising edges, after the divider has had time to settle.
	task automatic meas(input int w, output int q);
		int t;
		repeat (64) @(posedge clk);
		do @(posedge clk); while (pick(w) !== 1'b0);
		do @(posedge clk); while (pick(w) !== 1'b1);
		t = cyc;
		do @(posedge clk); while (pick(w) !== 1'b0);
		do @(posedge clk); while (pick(w) !== 1'b1);
		q = cyc - t;
	endtask

	task automatic irq_rise(output int t);
		do @(posedge clk); while (irq !== 1'b0);
		do @(posedge clk); while (irq !== 1'b1);
		t = cyc;
	endtask

	// Main sequence.
	initial begin
		seed = 32'h8333;
		{miscompares, n_compared, cyc} = '0;
		per = '{P0, P1, P2, P3};
		div = '{4, 16, 8, 32};
		{resetn, awvalid, wvalid, bready, arvalid, rready, mask, hins, wins, wake} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(MCCR_ADDR_CSR);
		chk(rdv, 32'h1);
		rd(MCCR_ADDR_CSR);
		chk(rdv, 32'h0);
		rd(MCCR_ADDR_MISC);
		chk(rdv, 32'h0);
		chk(coe, 1'b0);
		rd(12'h004);
		chk(resp, MCCR_RESP_SLVERR);
		wr(12'h008, 8'hff);
		chk(resp, MCCR_RESP_SLVERR);
		// Only the clock bits stick; a write without lane 0 is dropped.
		wr(MCCR_ADDR_MISC, 8'hff);
		rd(MCCR_ADDR_MISC);
		chk(rdv, 32'h27);
		wstrb <= 4'he;
		wr(MCCR_ADDR_MISC, 8'h00);
		wstrb <= 4'hf;
		rd(MCCR_ADDR_MISC);
		chk(rdv, 32'h27);
		meas(2, p);
		chk(p, 2);
		chk(coe, 1'b1);
		for (i = 0; i < 4; i++) begin
			wr(MCCR_ADDR_MISC, {3'b001, 2'b00, 2'(i), 1'b1});
			meas(0, p);
			chk(p, div[i]);
		end
		meas(1, p);
		chk(p, 2);
		wr(MCCR_ADDR_MISC, 8'h20);
		meas(0, p);
		chk(p, 2);
		// Every period code; a new code waits for the running period to end.
		wr(MCCR_ADDR_CSR, 8'h02);
		rd(MCCR_ADDR_CSR);
		irq_rise(t0);
		rd(MCCR_ADDR_CSR);
		for (i = 1; i < 5; i++) begin
			wr(MCCR_ADDR_CSR, {4'h0, 2'(i % 4), 2'b10});
			irq_rise(t1);
			rd(MCCR_ADDR_CSR);
			chk(t1 - t0, per[(i - 1) % 4]);
			irq_rise(t0);
			rd(MCCR_ADDR_CSR);
			chk(rdv, {28'h0, 2'(i % 4), 2'b11});
			chk(t0 - t1, per[i % 4]);
		end
		// Masked or disabled request stays low, yet the flag still sets.
		mask <= 1'b1;
		repeat (250) @(posedge clk);
		chk(irq, 1'b0);
		mask <= 1'b0;
		wr(MCCR_ADDR_CSR, 8'h00);
		rd(MCCR_ADDR_CSR);
		repeat (250) @(posedge clk);
		chk(irq, 1'b0);
		// Software uses whole-register writes only; such a write must leave the flag set.
		wr(MCCR_ADDR_CSR, 8'h00);
		rd(MCCR_ADDR_CSR);
		chk(rdv, 32'h1);
		// Wait ends on the request; active halt freezes writes and ends likewise.
		wr(MCCR_ADDR_CSR, 8'h02);
		rd(MCCR_ADDR_CSR);
		pulse(1'b0);
		chk(pm, PWR_WAIT);
		irq_rise(t0);
		chk(pm, PWR_RUN);
		rd(MCCR_ADDR_CSR);
		pulse(1'b1);
		chk(pm, PWR_ACTIVE_HALT);
		// Clock-out is still enabled here, so a running pin would show a one within four edges.
		repeat (4) begin
			@(posedge clk);
			chk(cko, 1'b0);
		end
		wr(MCCR_ADDR_CSR, 8'h0e);
		irq_rise(t0);
		chk(pm, PWR_RUN);
		rd(MCCR_ADDR_CSR);
		chk(rdv, 32'h3);
		// Full halt right after a period start: the count must not advance.
		wr(MCCR_ADDR_CSR, 8'h00);
		pulse(1'b1);
		chk(pm, PWR_HALT);
		repeat (800) @(posedge clk);
		chk(pm, PWR_HALT);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		@(posedge clk);
		chk(pm, PWR_RUN);
		rd(MCCR_ADDR_CSR);
		chk(rdv, 32'h0);
		wrap_up;
	end
endmodule
`default_nettype wire
